// [common/dacdb_map.svh]
// Purpose: Constants for the double-buffered converter load port
// Assumes: Two address inputs select four write locations
// Notes:   Codes are 14-bit unsigned
`ifndef DACDB_MAP_SVH
`define DACDB_MAP_SVH
`define DACDB_CODE_W    14
`define DACDB_UPPER_W   6
`define DACDB_LANE_W    8
`define DACDB_LOC_DIRECT 2'h0
`define DACDB_LOC_UPPER  2'h1
`define DACDB_LOC_LOWER  2'h2
`define DACDB_LOC_XFER   2'h3
`define DACDB_CODE_RST   14'h0000
`define DACDB_CODE_MAX   14'h3fff
`define DACDB_BIP_ZERO   14'h2000
`endif

// [common/dacdb_pkg.sv]
// Purpose: Types for the double-buffered converter load port
// Assumes: Constants come from dacdb_map.svh
// Notes:   Location codes follow the two address inputs
`include "dacdb_map.svh"
package dacdb_pkg;
  typedef enum logic [1:0]
  {
    dacdb_direct_t_v = `DACDB_LOC_DIRECT,
    dacdb_upper_t_v  = `DACDB_LOC_UPPER,
    dacdb_lower_t_v  = `DACDB_LOC_LOWER,
    dacdb_xfer_t_v   = `DACDB_LOC_XFER
  } dacdb_loc_t;
  typedef logic [`DACDB_CODE_W-1:0] dacdb_code_t;
endpackage

// [logic/dacdb_loader.sv]
// Purpose: Host write port with two input registers and a converter register
// Assumes: Strobes arrive asynchronously and are sampled on mclk
// Notes:   Capture happens when the write pulse ends, using data held one sample earlier
//          Pulses shorter than two mclk periods may be lost; hosts must stretch strobes
//          Address and byte are taken only while stages two and three agree on them
// Functional notes
// [RULE_01] The port decodes four write locations from its two address inputs, three used normally.
// [RULE_02] The host writes the upper six code bits, right-justified, to location one.
// [RULE_03] The host writes the lower eight code bits to location two.
// [RULE_04] A write to location three copies both input registers into the converter register.
// [RULE_05] Only eight data lines connect; a code takes two byte writes and a transfer write.
// [RULE_06] Any unsigned code from zero to the 14-bit maximum is accepted.
// [RULE_07] A host splitting a word may send the high and low bytes in either order.
// [RULE_08] In bipolar use the code is offset binary, top bit alone meaning zero output.
// [RULE_09] Nothing changes unless chip select and write strobe are both low.
// [RULE_10] A write to location zero loads all registers transparently from the byte.
// [RULE_11] The six low data lines carry bits 13..8 for the upper register, else bits 5..0.
// [RULE_12] Input registers hold their contents between writes, so byte order is free.
// [RULE_13] Registers capture at the end of the write pulse with data stable then.
`timescale 1ns/1ns
`include "dacdb_map.svh"
module dacdb_loader
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset,
  // Host pins
  input  wire logic                     chip_sel_n,
  input  wire logic                     write_n,
  input  wire logic                     addr_bit_high,
  input  wire logic                     addr_bit_low,
  input  wire logic [`DACDB_LANE_W-1:0] byte_lane,
  // Converter side
  output logic [`DACDB_CODE_W-1:0]      dac_code,
  output logic                          bipolar_zero
);
  localparam int PW = 2 + 2 + `DACDB_LANE_W;

  // Three-stage synchroniser on all pins; second and third must agree
  // All pins share one pipeline so strobe, address and byte stay aligned in time
  logic [PW-1:0] sync1_reg;
  logic [PW-1:0] sync2_reg;
  logic [PW-1:0] sync3_reg;
  logic [PW-1:0] pin_bus;
  assign pin_bus = {chip_sel_n, write_n, addr_bit_high, addr_bit_low, byte_lane};
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg <= {2'h3, {(PW-2){1'b0}}};
      sync2_reg <= {2'h3, {(PW-2){1'b0}}};
      sync3_reg <= {2'h3, {(PW-2){1'b0}}};
    end
    else
    begin
      sync1_reg <= pin_bus;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Filtered active level: updates only when stages two and three agree
  logic                     active_reg;
  logic [1:0]               loc_reg;
  logic [`DACDB_LANE_W-1:0] data_reg;
  wire  sel_agree  = (sync2_reg[PW-1:PW-2] == sync3_reg[PW-1:PW-2]);
  wire  both_low   = ~sync3_reg[PW-1] & ~sync3_reg[PW-2]; // RULE_09
  // Address and byte count only once stages two and three hold the same value
  wire  lane_agree = (sync2_reg[PW-3:0] == sync3_reg[PW-3:0]);
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      active_reg <= 1'b0;
      loc_reg    <= 2'h0;
      data_reg   <= 8'h00;
    end
    else if (sel_agree)
    begin
      active_reg <= both_low;
      // Address and data follow while the pulse is low, freeze at its end
      if (both_low && lane_agree)
      begin
        loc_reg  <= sync3_reg[PW-3:PW-4];
        data_reg <= sync3_reg[`DACDB_LANE_W-1:0];
      end
    end
  end

  // End of write pulse: the held address and byte are captured now
  wire  write_end = active_reg & sel_agree & ~both_low; // RULE_13
  dacdb_pkg::dacdb_loc_t loc;
  assign loc = dacdb_pkg::dacdb_loc_t'(loc_reg); // RULE_01
  wire  ld_direct = write_end & (loc == dacdb_pkg::dacdb_direct_t_v);
  wire  ld_upper  = write_end & (loc == dacdb_pkg::dacdb_upper_t_v) | ld_direct;
  wire  ld_lower  = write_end & (loc == dacdb_pkg::dacdb_lower_t_v) | ld_direct;
  wire  ld_xfer   = write_end & (loc == dacdb_pkg::dacdb_xfer_t_v);

  // Input registers and converter register
  logic [`DACDB_UPPER_W-1:0] upper_reg;
  logic [`DACDB_LANE_W-1:0]  lower_reg;
  logic [`DACDB_CODE_W-1:0]  code_reg;
  // Low six lines feed bits 13..8 for the upper register
  wire  [`DACDB_UPPER_W-1:0] upper_next = data_reg[`DACDB_UPPER_W-1:0]; // RULE_11
  // Direct load: upper bits take the same low six lines, so 00 or ff gives zero or full scale
  wire  [`DACDB_CODE_W-1:0]  direct_next = {upper_next, data_reg}; // RULE_10
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      upper_reg <= 6'h00;
      lower_reg <= 8'h00;
      code_reg  <= `DACDB_CODE_RST;
    end
    else
    begin
      // Each input register holds until addressed again
      if (ld_upper)
        upper_reg <= upper_next; // RULE_12
      if (ld_lower)
        lower_reg <= data_reg; // RULE_05
      if (ld_direct)
        code_reg <= direct_next; // RULE_10
      else if (ld_xfer)
        code_reg <= {upper_reg, lower_reg}; // RULE_04 RULE_06
    end
  end

  assign dac_code     = code_reg;
  // Flag the offset binary midpoint, useful when trimming bipolar zero
  assign bipolar_zero = (code_reg == `DACDB_BIP_ZERO); // RULE_08

  // Assertions
  // Transfer copies the two input registers as they stood before the edge
  property p_xfer;
    @(posedge mclk) disable iff (reset)
      ld_xfer |=> dac_code == {$past(upper_reg), $past(lower_reg)};
  endproperty
  a_xfer: assert property (p_xfer) else $error("Transfer did not load code"); // RULE_04

  // Nothing moves unless a pulse has just ended
  property p_hold;
    @(posedge mclk) disable iff (reset)
      !write_end |=> $stable(dac_code) && $stable(upper_reg) && $stable(lower_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("Register changed without write end"); // RULE_09

  // Upper load takes the low six lines and leaves the output alone
  property p_upper;
    @(posedge mclk) disable iff (reset)
      write_end && loc_reg == 2'h1 |=> upper_reg == $past(upper_next) && $stable(dac_code);
  endproperty
  a_upper: assert property (p_upper) else $error("Upper load wrong"); // RULE_11

  // Lower load takes the whole byte and leaves the upper register alone
  property p_lower;
    @(posedge mclk) disable iff (reset)
      write_end && loc_reg == 2'h2 |=> lower_reg == $past(data_reg) && $stable(upper_reg);
  endproperty
  a_lower: assert property (p_lower) else $error("Lower load wrong"); // RULE_03

  // Direct load sets the whole output from one byte
  property p_direct;
    @(posedge mclk) disable iff (reset)
      write_end && loc_reg == 2'h0 |=> dac_code == {$past(upper_next), $past(data_reg)};
  endproperty
  a_direct: assert property (p_direct) else $error("Direct load wrong"); // RULE_10

  // A pulse end needs a pulse that was already seen low a cycle earlier
  property p_end;
    @(posedge mclk) disable iff (reset)
      write_end |-> $past(active_reg);
  endproperty
  a_end: assert property (p_end) else $error("Capture outside pulse end"); // RULE_13

  // The largest code passes a transfer without losing a bit
  property p_range;
    @(posedge mclk) disable iff (reset)
      ld_xfer && upper_reg == 6'h3f && lower_reg == 8'hff |=> dac_code == `DACDB_CODE_MAX;
  endproperty
  a_range: assert property (p_range) else $error("Code out of range"); // RULE_06

  // The flag is only raised at the offset binary midpoint
  property p_bip;
    @(posedge mclk) disable iff (reset)
      bipolar_zero |-> dac_code[13] && dac_code[12:0] == 13'h0000;
  endproperty
  a_bip: assert property (p_bip) else $error("Bipolar zero flag wrong"); // RULE_08

  // The midpoint pattern always raises the flag
  property p_bip_set;
    @(posedge mclk) disable iff (reset)
      dac_code[13] && dac_code[12:0] == 13'h0000 |-> bipolar_zero;
  endproperty
  a_bip_set: assert property (p_bip_set) else $error("Bipolar zero flag missing"); // RULE_08

  // Direct load is transparent through both input registers
  property p_direct_in;
    @(posedge mclk) disable iff (reset)
      ld_direct |=> upper_reg == $past(upper_next) && lower_reg == $past(data_reg);
  endproperty
  a_direct_in: assert property (p_direct_in) else $error("Direct load skipped inputs"); // RULE_10

  // Transfer leaves the input registers ready for a repeat
  property p_xfer_in;
    @(posedge mclk) disable iff (reset)
      ld_xfer |=> $stable(upper_reg) && $stable(lower_reg);
  endproperty
  a_xfer_in: assert property (p_xfer_in) else $error("Transfer disturbed inputs"); // RULE_12

  // A lower load never reaches the output on its own
  property p_lower_code;
    @(posedge mclk) disable iff (reset)
      write_end && loc_reg == 2'h2 |=> $stable(dac_code);
  endproperty
  a_lower_code: assert property (p_lower_code) else $error("Lower load moved output"); // RULE_12

  // Each pulse gives exactly one capture strobe
  property p_one_shot;
    @(posedge mclk) disable iff (reset)
      write_end |=> !write_end;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("Capture strobe repeated"); // RULE_13

  // Main scenarios
  c_xfer:   cover property (@(posedge mclk) disable iff (reset) ld_xfer);
  c_direct: cover property (@(posedge mclk) disable iff (reset) ld_direct);
  c_seq:    cover property (@(posedge mclk) disable iff (reset) ld_upper ##[1:200] ld_xfer);
  c_lower:  cover property (@(posedge mclk) disable iff (reset) ld_lower && !ld_direct);
  c_bip:    cover property (@(posedge mclk) disable iff (reset) $rose(bipolar_zero));
endmodule

// [verification/dacdb_host_model.sv]
// Purpose: Host bus model that writes bytes to the converter port
// Assumes: Pins change on the falling edge of mclk
// Notes:   Released lines show inverted values so a late capture shows up
`timescale 1ns/1ns
module dacdb_host_model
(
  // Clock
  input  wire logic       mclk,
  // Host pins
  output logic            chip_sel_n,
  output logic            write_n,
  output logic            addr_bit_high,
  output logic            addr_bit_low,
  output logic [7:0]      byte_lane
);
  // Idle bus at time zero
  initial
  begin
    chip_sel_n = 1'b1;
    write_n = 1'b1;
    {addr_bit_high, addr_bit_low} = 2'h0;
    byte_lane = 8'h00;
  end
  // Six-cycle pulse, then six idle cycles so the port settles before the next one
  task automatic write_loc(input logic [1:0] loc, input logic [7:0] b,
                           input logic cs_n, input logic wr_n);
    @(negedge mclk);
    {addr_bit_high, addr_bit_low} = loc;
    byte_lane = b;
    chip_sel_n = cs_n;
    write_n = wr_n;
    repeat (6) @(negedge mclk);
    chip_sel_n = 1'b1;
    write_n = 1'b1;
    {addr_bit_high, addr_bit_low} = ~loc;
    byte_lane = ~b;
    repeat (6) @(negedge mclk);
  endtask
endmodule

// [verification/dacdb_loader_test.sv]
// Purpose: Self-checking bench for the converter load port
// Assumes: Updates land within five cycles of the pulse end
// Notes:   Expected codes are worked out by hand from the byte layout
`timescale 1ns/1ns
module dacdb_loader_test;
  logic                 mclk;
  logic                 reset;
  logic                 chip_sel_n;
  logic                 write_n;
  logic                 addr_bit_high;
  logic                 addr_bit_low;
  logic [7:0]           byte_lane;
  dacdb_pkg::dacdb_code_t dac_code;
  logic                 bipolar_zero;
  int                   err_total;
  int                   num_checks;
  int                   cycles;
  // Clock and a cycle ceiling far above the roughly 150 cycles used
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      conclude();
    end
  end
  dacdb_loader dacdb_loader_inst(.mclk(mclk), .reset(reset), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .addr_bit_high(addr_bit_high), .addr_bit_low(addr_bit_low),
    .byte_lane(byte_lane), .dac_code(dac_code), .bipolar_zero(bipolar_zero));
  dacdb_host_model dacdb_host_model_inst(.mclk(mclk), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .addr_bit_high(addr_bit_high), .addr_bit_low(addr_bit_low),
    .byte_lane(byte_lane));
  // Compare and report
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [1:0] loc, input logic [7:0] b);
    dacdb_host_model_inst.write_loc(loc, b, 1'b0, 1'b0);
  endtask
  // Calibration loads through the transparent location
  task automatic t_direct;
    wr(dacdb_pkg::dacdb_direct_t_v, 8'hff);
    check(dac_code, 14'h3fff);
    wr(dacdb_pkg::dacdb_xfer_t_v, 8'h00);
    check(dac_code, 14'h3fff);
    wr(dacdb_pkg::dacdb_direct_t_v, 8'h00);
    check(dac_code, 14'h0000);
  endtask
  // High byte first; input loads must not reach the output before transfer
  task automatic t_double;
    wr(dacdb_pkg::dacdb_upper_t_v, 8'hea);
    check(dac_code, 14'h0000);
    wr(dacdb_pkg::dacdb_lower_t_v, 8'h55);
    check(dac_code, 14'h0000);
    wr(dacdb_pkg::dacdb_xfer_t_v, 8'h00);
    check(dac_code, 14'h2a55);
    check({13'h0, bipolar_zero}, 14'h0000);
  endtask
  // Low byte first, one transfer to the midpoint, then gated strobes
  task automatic t_order_gate;
    wr(dacdb_pkg::dacdb_lower_t_v, 8'h00);
    wr(dacdb_pkg::dacdb_upper_t_v, 8'h20);
    wr(dacdb_pkg::dacdb_xfer_t_v, 8'hff);
    check(dac_code, 14'h2000);
    check({13'h0, bipolar_zero}, 14'h0001);
    dacdb_host_model_inst.write_loc(2'h0, 8'hff, 1'b1, 1'b0);
    dacdb_host_model_inst.write_loc(2'h0, 8'hff, 1'b0, 1'b1);
    check(dac_code, 14'h2000);
  endtask
  // Main sequence
  initial
  begin
    err_total = 0;
    num_checks = 0;
    reset = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    check(dac_code, 14'h0000);
    t_direct();
    t_double();
    t_order_gate();
    conclude();
  end
endmodule
